// *** hdl/iww_consts.vh ***
// Constants for the independent window watchdog
// What this block does
// RQ1: Eight-stage prescaler feeds a twelve-bit down counter, stepped by oscillator ticks.
// RQ2: Start code in command register enables the watchdog; counter then decrements.
// RQ3: Running counter at zero raises the system reset.
// RQ4: Reload code loads the counter from the reload value at any time.
// RQ5: Reload while counter exceeds window limit raises system reset instead.
// RQ6: Window limit resets to 0xfff, so the window check is off.
// RQ7: A window limit change reloads the counter and restarts the prescaler.
// RQ8: Hardware option bit set starts the watchdog at power-on without software.
// RQ9: Divider, reload and window registers ignore writes until unlock code is written.
// RQ10: Any other command value restores write protection of those registers.
// RQ11: Status bit 0 reads one while a divider write is being transferred.
// RQ12: Status bit 1 reads one while a reload value write is pending.
// RQ13: Status bit 2 reads one while a window limit write is pending.
// RQ14: Divider codes 0 to 5 divide by 4 to 128; codes 6, 7 by 256.
// RQ15: Counting continues in debug halt unless the freeze input is high.
// RQ16: Logic keeps working from the oscillator when the main clock fails; here all logic runs on the bus clock and only samples the oscillator.
// RQ17: Software waits for divider pending clear before another divider write.
// RQ18: Software waits for reload pending clear before another reload value write.
// RQ19: Software waits over three oscillator periods after reload before deep sleep.
// RQ20: Command, reload and status registers accept half-word and word accesses.
// RQ21: Window register holds a write-protected twelve-bit limit at offset 0x10.
// RQ22: Pending bits clear by themselves once the value reaches the oscillator side.
`ifndef IWW_CONSTS_VH
`define IWW_CONSTS_VH

`define IWW_OFS_COMMAND  8'h00
`define IWW_OFS_DIVIDER  8'h04
`define IWW_OFS_RELOAD   8'h08
`define IWW_OFS_STATUS   8'h0c
`define IWW_OFS_WINDOW   8'h10

`define IWW_CMD_UNLOCK   16'h5555
`define IWW_CMD_START    16'hcccc
`define IWW_CMD_RELOAD   16'haaaa

`define IWW_RST_DIVIDER  3'h0
`define IWW_RST_RELOAD   12'hfff
`define IWW_RST_WINDOW   12'hfff
`define IWW_RST_COUNTER  12'hfff

`define IWW_BIT_DIV_PEND 0
`define IWW_BIT_RLD_PEND 1
`define IWW_BIT_WND_PEND 2

`define IWW_SYNC_TICKS   2'h2

`endif

// *** hdl/iww_top.v ***
// Independent window watchdog: register slave, oscillator-side counter and reset logic
//
// Added by the designer: the strobed register port.
`timescale 1ns/1ps
`include "iww_consts.vh"

module iww_top (
  input  wire        clock,
  input  wire        nrst,
  input  wire [7:0]  addr,
  input  wire [31:0] wdata,
  input  wire        wr,
  input  wire        rd,
  output reg  [31:0] rdata,
  input  wire        low_speed_oscillator,
  input  wire        hw_watchdog_option,
  input  wire        debug_halt,
  input  wire        debug_freeze_input,
  output reg         system_reset_out,
  output reg         watchdog_running
);

  // Last prescaler count for a divider code
  function [7:0] iww_div_last;
    input [2:0] code;
    begin
      if (code >= 3'h6) begin
        iww_div_last = 8'hff; // [RQ14]
      end else begin
        iww_div_last = (8'h04 << code) - 8'h01; // [RQ14]
      end
    end
  endfunction

  // Pending counter step: restart on a new write, count ticks, stop at the end
  function [1:0] iww_sync_step;
    input       new_write;
    input       tick;
    input [1:0] cnt;
    begin
      if (new_write) begin
        iww_sync_step = 2'h0;
      end else if (tick && cnt != `IWW_SYNC_TICKS) begin
        iww_sync_step = cnt + 2'h1;
      end else begin
        iww_sync_step = cnt;
      end
    end
  endfunction

  reg         osc_prev;
  reg         init_done;
  reg         unlocked;
  reg  [2:0]  bus_divider;
  reg  [11:0] bus_reload;
  reg  [11:0] bus_window;
  reg  [2:0]  act_divider;
  reg  [11:0] act_reload;
  reg  [11:0] act_window;
  reg  [2:0]  pending;
  reg  [1:0]  div_sync;
  reg  [1:0]  rld_sync;
  reg  [1:0]  wnd_sync;
  reg  [7:0]  prescaler;
  reg  [11:0] counter;

  wire        osc_tick;
  wire        cmd_wr;
  wire        div_wr;
  wire        rld_wr;
  wire        wnd_wr;
  wire        reload_cmd;
  wire        window_apply;
  wire        count_ok;
  wire        presc_wrap;
  wire [1:0]  next_div_sync;
  wire [1:0]  next_rld_sync;
  wire [1:0]  next_wnd_sync;

  // Oscillator is sampled as a level; its rising edge is the watchdog time base
  assign osc_tick = low_speed_oscillator & ~osc_prev; // [RQ1] [RQ16]

  // Only the low half-word is decoded, so half-word and word writes act alike
  assign cmd_wr = wr && addr == `IWW_OFS_COMMAND; // [RQ20]
  assign div_wr = wr && addr == `IWW_OFS_DIVIDER && unlocked; // [RQ9]
  assign rld_wr = wr && addr == `IWW_OFS_RELOAD && unlocked; // [RQ9]
  assign wnd_wr = wr && addr == `IWW_OFS_WINDOW && unlocked; // [RQ9] [RQ21]

  assign reload_cmd = cmd_wr && wdata[15:0] == `IWW_CMD_RELOAD; // [RQ4]

  assign next_div_sync = iww_sync_step(div_wr, osc_tick, div_sync); // [RQ22]
  assign next_rld_sync = iww_sync_step(rld_wr, osc_tick, rld_sync); // [RQ22]
  assign next_wnd_sync = iww_sync_step(wnd_wr, osc_tick, wnd_sync); // [RQ22]

  // Window value lands on the oscillator side in this cycle
  assign window_apply = pending[`IWW_BIT_WND_PEND] && !wnd_wr &&
                        next_wnd_sync == `IWW_SYNC_TICKS; // [RQ7]

  // Freeze only when the core is halted and the freeze input asks for it
  assign count_ok   = watchdog_running && osc_tick &&
                      !(debug_halt && debug_freeze_input); // [RQ15]
  assign presc_wrap = prescaler == iww_div_last(act_divider); // [RQ1] [RQ14]

  // Bus side: unlock state, staged values and pending flags
  always @(posedge clock) begin
    if (!nrst) begin
      osc_prev    <= 1'b0;
      unlocked    <= 1'b0;
      bus_divider <= `IWW_RST_DIVIDER;
      bus_reload  <= `IWW_RST_RELOAD;
      bus_window  <= `IWW_RST_WINDOW; // [RQ6]
      pending     <= 3'h0;
      div_sync    <= 2'h0;
      rld_sync    <= 2'h0;
      wnd_sync    <= 2'h0;
    end else begin
      osc_prev <= low_speed_oscillator;
      if (cmd_wr) begin
        unlocked <= wdata[15:0] == `IWW_CMD_UNLOCK; // [RQ9] [RQ10]
      end
      if (div_wr) begin
        bus_divider <= wdata[2:0];
      end
      if (rld_wr) begin
        bus_reload <= wdata[11:0];
      end
      if (wnd_wr) begin
        bus_window <= wdata[11:0];
      end
      div_sync <= next_div_sync;
      rld_sync <= next_rld_sync;
      wnd_sync <= next_wnd_sync;
      // A new write re-arms its flag even in the cycle the old one completes
      if (div_wr) begin
        pending[`IWW_BIT_DIV_PEND] <= 1'b1; // [RQ11]
      end else if (next_div_sync == `IWW_SYNC_TICKS) begin
        pending[`IWW_BIT_DIV_PEND] <= 1'b0; // [RQ22]
      end
      if (rld_wr) begin
        pending[`IWW_BIT_RLD_PEND] <= 1'b1; // [RQ12]
      end else if (next_rld_sync == `IWW_SYNC_TICKS) begin
        pending[`IWW_BIT_RLD_PEND] <= 1'b0; // [RQ22]
      end
      if (wnd_wr) begin
        pending[`IWW_BIT_WND_PEND] <= 1'b1; // [RQ13]
      end else if (next_wnd_sync == `IWW_SYNC_TICKS) begin
        pending[`IWW_BIT_WND_PEND] <= 1'b0; // [RQ22]
      end
    end
  end

  // Values in use by the counter follow the staged ones after the transfer
  always @(posedge clock) begin
    if (!nrst) begin
      act_divider <= `IWW_RST_DIVIDER;
      act_reload  <= `IWW_RST_RELOAD;
      act_window  <= `IWW_RST_WINDOW; // [RQ6]
    end else begin
      if (pending[`IWW_BIT_DIV_PEND] && !div_wr && next_div_sync == `IWW_SYNC_TICKS) begin
        act_divider <= bus_divider; // [RQ22]
      end
      if (pending[`IWW_BIT_RLD_PEND] && !rld_wr && next_rld_sync == `IWW_SYNC_TICKS) begin
        act_reload <= bus_reload; // [RQ22]
      end
      if (window_apply) begin
        act_window <= bus_window; // [RQ21] [RQ22]
      end
    end
  end

  // Start: by software code, or by the option bit caught just after reset release
  always @(posedge clock) begin
    if (!nrst) begin
      init_done        <= 1'b0;
      watchdog_running <= 1'b0;
    end else begin
      init_done <= 1'b1;
      if (!init_done && hw_watchdog_option) begin
        watchdog_running <= 1'b1; // [RQ8]
      end else if (cmd_wr && wdata[15:0] == `IWW_CMD_START) begin
        watchdog_running <= 1'b1; // [RQ2]
      end
    end
  end

  // Prescaler and down counter; software reload beats window reload beats counting
  always @(posedge clock) begin
    if (!nrst) begin
      prescaler <= 8'h00;
      counter   <= `IWW_RST_COUNTER;
    end else if (reload_cmd) begin
      counter   <= act_reload; // [RQ4]
      prescaler <= 8'h00;
    end else if (window_apply) begin
      counter   <= act_reload; // [RQ7]
      prescaler <= 8'h00; // [RQ7]
    end else if (count_ok) begin
      if (presc_wrap) begin
        prescaler <= 8'h00;
        if (counter != 12'h000) begin
          counter <= counter - 12'h001; // [RQ2]
        end
      end else begin
        prescaler <= prescaler + 8'h01; // [RQ1]
      end
    end
  end

  // Reset request holds until the system reset clears the block
  always @(posedge clock) begin
    if (!nrst) begin
      system_reset_out <= 1'b0;
    end else if (watchdog_running && counter == 12'h000) begin
      system_reset_out <= 1'b1; // [RQ3]
    end else if (watchdog_running && reload_cmd && counter > act_window) begin
      system_reset_out <= 1'b1; // [RQ5]
    end
  end

  // Read data stand only in the cycle after the read strobe
  always @(posedge clock) begin
    if (!nrst) begin
      rdata <= 32'h0000_0000;
    end else if (rd) begin
      case (addr)
        `IWW_OFS_DIVIDER: rdata <= {29'h0, bus_divider};
        `IWW_OFS_RELOAD:  rdata <= {20'h0, bus_reload};
        `IWW_OFS_STATUS:  rdata <= {29'h0, pending}; // [RQ11] [RQ12] [RQ13] [RQ20]
        `IWW_OFS_WINDOW:  rdata <= {20'h0, bus_window};
        default:          rdata <= 32'h0000_0000;
      endcase
    end else begin
      rdata <= 32'h0000_0000;
    end
  end

endmodule // iww_top

// *** sim/iww_chk.sv ***
// Assertion checker on the watchdog top-level ports
`timescale 1ns/1ps
module iww_chk (
  input wire        clock,
  input wire        nrst,
  input wire [7:0]  addr,
  input wire [31:0] wdata,
  input wire        wr,
  input wire        rd,
  input wire [31:0] rdata,
  input wire        system_reset_out,
  input wire        watchdog_running
);
  reg unl;
  // Mirror of the unlock state so pending checks only follow accepted writes
  always @(posedge clock) begin
    if (!nrst) unl <= 1'b0;
    else if (wr && addr == 8'h00) unl <= (wdata[15:0] == 16'h5555);
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  a_start_runs:
  assert property (wr && addr == 8'h00 && wdata[15:0] == 16'hcccc |=> watchdog_running)
    else $error("start code ignored");
  a_run_sticky:
  assert property (watchdog_running |=> watchdog_running) else $error("watchdog stopped");
  a_rst_sticky:
  assert property (system_reset_out |=> system_reset_out) else $error("reset dropped");
  a_rst_needs_run:
  assert property ($rose(system_reset_out) |-> $past(watchdog_running))
    else $error("reset while stopped");
  a_idle_zero:
  assert property (!rd |=> rdata == 32'h0) else $error("read data without read");
  a_div_pend:
  assert property (wr && addr == 8'h04 && unl ##2 rd && addr == 8'h0c |=> rdata[0])
    else $error("divider pending missing");
  a_rld_pend:
  assert property (wr && addr == 8'h08 && unl ##2 rd && addr == 8'h0c |=> rdata[1])
    else $error("reload pending missing");
  a_wnd_pend:
  assert property (wr && addr == 8'h10 && unl ##2 rd && addr == 8'h0c |=> rdata[2])
    else $error("window pending missing");
endmodule // iww_chk
bind iww_top iww_chk i_chk (.clock(clock), .nrst(nrst), .addr(addr), .wdata(wdata),
  .wr(wr), .rd(rd), .rdata(rdata), .system_reset_out(system_reset_out),
  .watchdog_running(watchdog_running));

// *** sim/iww_top_test.sv ***
// Directed testbench for the independent window watchdog
`timescale 1ns/1ps
module iww_top_test;
  reg         clock = 1'b0;
  reg         nrst = 1'b0;
  reg  [7:0]  addr = 8'h00;
  reg  [31:0] wdata = 32'h0;
  reg         wr = 1'b0;
  reg         rd = 1'b0;
  reg         osc = 1'b0;
  reg         hw_opt = 1'b0;
  reg         halt = 1'b0;
  reg         frz = 1'b0;
  wire [31:0] rdata;
  wire        sys_rst;
  wire        running;
  integer     failures = 0;
  integer     tests_run = 0;
  integer     cyc = 0;
  integer     n;
  iww_top i_dut (.clock(clock), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .low_speed_oscillator(osc), .hw_watchdog_option(hw_opt),
    .debug_halt(halt), .debug_freeze_input(frz), .system_reset_out(sys_rst),
    .watchdog_running(running));
  always #5 clock = ~clock;
  // Oscillator at one eighth of the bus clock keeps timeouts short
  always #40 osc = ~osc;
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      failures = failures + 1;
      end_of_test;
    end
  end
  task end_of_test;
    begin
      if (failures == 0 && tests_run > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
    end
  endtask
  task check(input [31:0] seen, input [31:0] exp);
    begin
      tests_run = tests_run + 1;
      if (seen !== exp) begin
        failures = failures + 1;
        $display("[ERR] %0t saw %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task wr_reg(input [7:0] a, input [31:0] d);
    begin
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clock);
      wr <= 1'b0;
      @(posedge clock);
    end
  endtask
  task rd_chk(input [7:0] a, input [31:0] e);
    begin
      addr <= a;
      rd <= 1'b1;
      @(posedge clock);
      rd <= 1'b0;
      @(negedge clock);
      check(rdata, e);
      @(posedge clock);
    end
  endtask
  task do_reset(input opt);
    begin
      nrst <= 1'b0;
      hw_opt <= opt;
      repeat (6) @(posedge clock);
      nrst <= 1'b1;
      @(posedge clock);
    end
  endtask
  initial begin
    do_reset(1'b0);
    rd_chk(8'h04, 32'h0);
    rd_chk(8'h08, 32'hfff);
    rd_chk(8'h10, 32'hfff);
    rd_chk(8'h00, 32'h0);
    wr_reg(8'h08, 32'h123);
    rd_chk(8'h08, 32'hfff);
    wr_reg(8'h00, 32'h5555);
    wr_reg(8'h08, 32'h5);
    rd_chk(8'h0c, 32'h2);
    repeat (40) @(posedge clock);
    rd_chk(8'h0c, 32'h0);
    wr_reg(8'h04, 32'h0);
    rd_chk(8'h0c, 32'h1);
    wr_reg(8'h00, 32'h0);
    wr_reg(8'h08, 32'h777);
    rd_chk(8'h08, 32'h5);
    repeat (40) @(posedge clock);
    wr_reg(8'h00, 32'hcccc);
    @(negedge clock);
    check({31'h0, running}, 32'h1);
    @(posedge clock);
    halt <= 1'b1;
    frz <= 1'b1;
    wr_reg(8'h00, 32'haaaa);
    repeat (300) @(posedge clock);
    @(negedge clock);
    check({31'h0, sys_rst}, 32'h0);
    @(posedge clock);
    frz <= 1'b0;
    n = 0;
    while (sys_rst !== 1'b1 && n < 400) begin
      @(negedge clock);
      n = n + 1;
    end
    // Reload 5 at divide-by-4 is 20 oscillator ticks, one tick of phase slack
    check({31'h0, (n >= 150 && n <= 175)}, 32'h1);
    @(posedge clock);
    do_reset(1'b1);
    @(negedge clock);
    check({31'h0, running}, 32'h1);
    @(posedge clock);
    wr_reg(8'h00, 32'haaaa);
    @(negedge clock);
    check({31'h0, sys_rst}, 32'h0);
    @(posedge clock);
    wr_reg(8'h00, 32'h5555);
    wr_reg(8'h10, 32'h2);
    rd_chk(8'h0c, 32'h4);
    rd_chk(8'h10, 32'h2);
    repeat (40) @(posedge clock);
    wr_reg(8'h00, 32'haaaa);
    @(negedge clock);
    check({31'h0, sys_rst}, 32'h1);
    @(posedge clock);
    do_reset(1'b0);
    @(negedge clock);
    check({31'h0, running}, 32'h0);
    @(posedge clock);
    wr_reg(8'h00, 32'h5555);
    wr_reg(8'h04, 32'h7);
    wr_reg(8'h08, 32'h1);
    repeat (40) @(posedge clock);
    rd_chk(8'h0c, 32'h0);
    wr_reg(8'h00, 32'hcccc);
    wr_reg(8'h00, 32'haaaa);
    n = 0;
    while (sys_rst !== 1'b1 && n < 2200) begin
      @(negedge clock);
      n = n + 1;
    end
    // Reload 1 at divide-by-256 is 256 ticks of 8 clocks, one tick of phase slack
    check({31'h0, (n >= 2030 && n <= 2070)}, 32'h1);
    end_of_test;
  end
endmodule // iww_top_test
